// [inc/radio_test_pkg.sv]
// Constants and carrier types for the radio test and status register bank
package radio_test_pkg;

  // ********************************************************************
  // Register indices (byte address is four times the index)
  // ********************************************************************
  localparam logic [7:0] IDX_PUMP_MIXER = 8'h24; // test_charge_pump_mixer
  localparam logic [7:0] IDX_ADC_DITHER = 8'h25; // test_adc_dither
  localparam logic [7:0] IDX_VGA_COUPLER = 8'h26; // coupler override
  localparam logic [7:0] IDX_VGA_STAGE = 8'h27; // stage override
  localparam logic [7:0] IDX_TEST_MODULE = 8'h30; // test module control
  localparam logic [7:0] IDX_CARRIER_LEVEL = 8'h31; // carrier threshold
  localparam logic [7:0] IDX_STATUS = 8'h40; // radio_status_flags
  localparam logic [7:0] IDX_RESET_OK = 8'h41; // subblock_reset_complete

  // ********************************************************************
  // Values after reset
  // ********************************************************************
  localparam logic [7:0] RST_PUMP_MIXER = 8'h00; // All tests off
  localparam logic [7:0] RST_ADC_DITHER = 8'h40; // Dither on
  localparam logic [3:0] RST_VGA_COUPLER = 4'h0; // No override
  localparam logic [5:0] RST_VGA_STAGE = 6'h00; // Zero stage values
  localparam logic [3:0] RST_TEST_MODULE = 4'h0; // Interface bits
  localparam logic [6:0] RST_CARRIER_LEVEL = 7'h00; // Threshold
  localparam logic [2:0] TEST_MODE_IDLE = 3'h4; // Mode bit 2 forced

  // ********************************************************************
  // Rotation sequence selections
  // ********************************************************************
  localparam logic [1:0] ROT_MODE_ASCEND = 2'h0; // 00 01 10 11
  localparam logic [1:0] ROT_MODE_GRAY = 2'h1; // 00 10 11 01
  localparam logic [1:0] ROT_MODE_FIXED = 2'h2; // Always 00
  localparam logic [1:0] ROT_MODE_PAIR = 2'h3; // 00 10 00 10

  // ********************************************************************
  // Carrier types
  // ********************************************************************
  typedef struct packed {
    logic pump_normal_off; // Bit 7
    logic pump_force_up; // Bit 6
    logic pump_force_down; // Bit 5
    logic [1:0] mixer_dc_polarity; // Bits 4:3, I then Q
    logic mixer_dc_control_en; // Bit 2
    logic test_module_to_filter; // Bit 1
    logic test_module_to_converter; // Bit 0
  } pump_mixer_t;

  typedef struct packed {
    logic freq_comp_out_en; // Bit 7
    logic sigma_clock_dither_en; // Bit 6
    logic converter_test_out; // Bit 5
    logic integrator_chop_off; // Bit 4
    logic feedback_shaping_off; // Bit 3
    logic common_mode_rotation_off; // Bit 2
    logic [1:0] rotation_mode; // Bits 1:0
  } adc_dither_t;

  typedef struct packed {
    logic vga_override; // Bit 3
    logic coupler_one_gain; // Bit 2
    logic [1:0] coupler_two_gain; // Bits 1:0
  } vga_coupler_t;

  typedef struct packed {
    logic [1:0] gain_stage_one_value; // Bits 5:4
    logic [1:0] gain_stage_two_value; // Bits 3:2
    logic [1:0] gain_stage_three_value; // Bits 1:0
  } vga_stage_t;

  typedef struct packed {
    logic coupler_one_gain; // First coupler
    logic [1:0] coupler_two_gain; // Second coupler
    vga_stage_t stages; // Three gain stages
  } vga_setting_t;

  typedef struct packed {
    logic cal_complete; // Bit 7
    logic powerup_sequence_fault; // Bit 6
    logic pll_lock_raw; // Bit 5
    logic pll_lock_filtered; // Bit 4
    logic carrier_sense; // Bit 3
    logic lock_pin; // Bit 2
    logic data_clock_pin; // Bit 1
    logic data_pin; // Bit 0
  } status_t;

  typedef struct packed {
    logic converter_reset_ok; // Bit 7
    logic gain_ctrl_reset_ok; // Bit 6
    logic shaping_filter_reset_ok; // Bit 5
    logic freq_correction_reset_ok; // Bit 4
    logic bit_timing_reset_ok; // Bit 3
    logic synthesizer_reset_ok; // Bit 2
    logic sequencer_reset_ok; // Bit 1
    logic cal_lock_reset_ok; // Bit 0
  } reset_ok_t;

  typedef struct packed {
    logic lock; // Lock pin level
    logic data_clock; // Data clock pin level
    logic data; // Data pin level
    logic data_oe; // Data pin enable, high drives
  } pin_drive_t;

  typedef struct packed {
    logic psel; // Select
    logic penable; // Access phase
    logic pwrite; // Direction
    logic [11:0] paddr; // Byte address
    logic [31:0] pwdata; // Write data
  } apb_req_t;

  typedef struct packed {
    logic pready; // Ready
    logic [31:0] prdata; // Read data
    logic pslverr; // Error
  } apb_rsp_t;

endpackage : radio_test_pkg

// [src/pin_level_sync.sv]
// Two-flop synchroniser for pin levels entering the register clock
`timescale 1ns/100ps
module pin_level_sync #(
  parameter int WIDTH = 4 // Number of levels carried
) (
  input wire logic ref_clk_i, // Register clock
  input wire logic reset_n_i, // Async reset, active low
  input wire logic [WIDTH-1:0] async_i, // Levels from pins
  output logic [WIDTH-1:0] sync_o // Levels safe to use
);

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    logic [WIDTH-1:0] meta; // First stage, read only by second
    logic [WIDTH-1:0] stable; // Second stage
  } sync_state_t;

  sync_state_t state_q; // Registered state
  sync_state_t state_d; // Next state

  // Shift one stage per edge
  always_comb begin
    state_d = state_q;
    state_d.meta = async_i;
    state_d.stable = state_q.meta;
  end

  // Constants only under reset
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign sync_o = state_q.stable;

endmodule : pin_level_sync

// [src/rf_test_and_status_registers.sv]
// Test override and status register bank with APB slave port
`timescale 1ns/100ps
module rf_test_and_status_registers (
  input wire logic ref_clk_i, // 100 MHz clock
  input wire logic reset_n_i, // Async reset, active low
  input radio_test_pkg::apb_req_t apb_i, // APB request
  output radio_test_pkg::apb_rsp_t apb_o, // APB answer
  // Charge pump and mixer controls
  output logic pump_normal_off_o, // Normal pump stopped
  output logic pump_force_up_o, // Constant up current
  output logic pump_force_down_o, // Constant down current
  output logic mixer_dc_control_en_o, // Mixer under DC control
  output logic [1:0] mixer_dc_polarity_o, // {I pos, Q pos}
  output logic test_module_to_filter_o, // Route to filter
  output logic test_module_to_converter_o, // Route to converter
  output logic test_module_powerdown_o, // Test module off
  output logic [2:0] test_mode_o, // Test module mode
  // Converter and synthesiser controls
  output logic freq_comp_out_en_o, // Comparator output on
  output logic sigma_clock_dither_en_o, // Dither on
  output logic integrator_chop_off_o, // Chopping off
  output logic feedback_shaping_off_o, // Shaping off
  output logic common_mode_rotation_off_o, // Rotation off
  input wire logic rotate_step_i, // Advance rotation, pulse
  output logic [1:0] rotation_position_o, // Rotation position
  // Gain chain
  input radio_test_pkg::vga_setting_t agc_setting_i, // From AGC
  output radio_test_pkg::vga_setting_t vga_setting_o, // Applied
  // Converter test path and pins
  input wire logic [1:0] adc_sample_i, // {lock pin, data pin} bits
  input wire logic adc_clk_i, // Converter sample clock level
  input radio_test_pkg::pin_drive_t normal_pins_i, // Normal use
  output radio_test_pkg::pin_drive_t pins_o, // To pads
  input wire logic lock_pin_i, // Lock pad level
  input wire logic data_clock_pin_i, // Data clock pad level
  input wire logic data_pin_i, // Data pad level
  // Status sources
  input wire logic cal_start_i, // Calibration begins, pulse
  input wire logic cal_done_i, // Calibration ends, pulse
  input wire logic seq_start_i, // Power-up sequence begins
  input wire logic seq_lock_fail_i, // Sequence lock failure
  input wire logic pll_lock_raw_i, // Raw lock, asynchronous
  input wire logic pll_lock_filtered_i, // Filtered lock
  input wire logic [6:0] rssi_i, // Signal strength
  input radio_test_pkg::reset_ok_t reset_ok_i // Sub-block resets
);
  import radio_test_pkg::*;

  // ********************************************************************
  // Helper functions
  // ********************************************************************

  // Register index from a byte address
  function automatic logic [7:0] reg_index(input logic [11:0] addr);
    return addr[9:2];
  endfunction : reg_index

  // Address lands on a word of the map
  function automatic logic addr_mapped(input logic [11:0] addr,
                                       input logic wr);
    logic [7:0] idx;
    logic hit;
    idx = addr[9:2];
    hit = (addr[11:10] == 2'b00) && (addr[1:0] == 2'b00);
    unique case (idx)
      IDX_PUMP_MIXER, IDX_ADC_DITHER, IDX_VGA_COUPLER, IDX_VGA_STAGE,
      IDX_TEST_MODULE, IDX_CARRIER_LEVEL: return hit;
      IDX_STATUS, IDX_RESET_OK: return hit && !wr; // Read-only
      default: return 1'b0;
    endcase
  endfunction : addr_mapped

  // Converter input rotation position from step count
  function automatic logic [1:0] rotation_lookup(input logic [1:0] mode,
                                                 input logic [1:0] idx);
    logic [1:0] pos;
    pos = 2'b00;
    unique case (mode)
      ROT_MODE_ASCEND: pos = idx;
      ROT_MODE_GRAY: begin
        unique case (idx)
          2'd0: pos = 2'b00;
          2'd1: pos = 2'b10;
          2'd2: pos = 2'b11;
          2'd3: pos = 2'b01;
        endcase
      end
      ROT_MODE_FIXED: pos = 2'b00;
      ROT_MODE_PAIR: pos = {idx[0], 1'b0};
    endcase
    return pos;
  endfunction : rotation_lookup

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    pump_mixer_t pm; // Pump and mixer word
    adc_dither_t ad; // Converter and dither word
    vga_coupler_t vc; // Coupler override, reserved bits dropped
    vga_stage_t vs; // Stage override, reserved bits dropped
    logic [3:0] tm_ctrl; // Test module powerdown and mode
    logic [6:0] cs_level; // Carrier threshold
    logic cal_complete; // Calibration flag
    logic seq_fault; // Power-up sequence fault
    logic [1:0] rot_idx; // Rotation step count
    logic [1:0] rot_pos; // Rotation position
    logic tm_pd; // Test module powerdown
    logic [2:0] tm_mode; // Test module mode
    vga_setting_t vga; // Applied gain setting
    pin_drive_t pins; // Pad drive
    logic [31:0] prdata; // Read data
    logic pslverr; // Error answer
  } state_t;

  state_t st_q; // Registered state
  state_t st_d; // Next state
  logic [3:0] pin_sync; // Synchronised {raw lock, lock, clk, data}
  status_t status; // Live status word
  logic wr_access; // Write completing this edge
  logic setup; // Setup phase
  logic [7:0] idx; // Addressed register

  // ********************************************************************
  // Pin level synchroniser
  // ********************************************************************
  // Pads and the raw lock detector are outside this clock
  pin_level_sync #(
    .WIDTH(4)
  ) u_pin_sync (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .async_i({pll_lock_raw_i, lock_pin_i, data_clock_pin_i, data_pin_i}),
    .sync_o(pin_sync)
  );

  // ********************************************************************
  // Status word and bus decode
  // ********************************************************************
  always_comb begin
    status.cal_complete = st_q.cal_complete;
    status.powerup_sequence_fault = st_q.seq_fault;
    status.pll_lock_raw = pin_sync[3];
    status.pll_lock_filtered = pll_lock_filtered_i;
    status.carrier_sense = (rssi_i > st_q.cs_level);
    status.lock_pin = pin_sync[2];
    status.data_clock_pin = pin_sync[1];
    status.data_pin = pin_sync[0];
  end

  assign idx = reg_index(apb_i.paddr);
  assign setup = apb_i.psel && !apb_i.penable;
  // Zero wait states: every access phase completes
  assign wr_access = apb_i.psel && apb_i.penable && apb_i.pwrite &&
                     addr_mapped(apb_i.paddr, 1'b1);

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    st_d = st_q;
    // Register writes; reserved bits are simply not stored
    if (wr_access) begin
      unique case (idx)
        IDX_PUMP_MIXER: st_d.pm = apb_i.pwdata[7:0];
        IDX_ADC_DITHER: st_d.ad = apb_i.pwdata[7:0];
        IDX_VGA_COUPLER: st_d.vc = apb_i.pwdata[3:0];
        IDX_VGA_STAGE: st_d.vs = apb_i.pwdata[5:0];
        IDX_TEST_MODULE: st_d.tm_ctrl = apb_i.pwdata[3:0];
        IDX_CARRIER_LEVEL: st_d.cs_level = apb_i.pwdata[6:0];
        default: st_d.pm = st_q.pm;
      endcase
    end
    // Read data captured in setup so it comes from a flop
    if (setup) begin
      st_d.pslverr = !addr_mapped(apb_i.paddr, apb_i.pwrite);
      st_d.prdata = 32'h0000_0000;
      if (!apb_i.pwrite && addr_mapped(apb_i.paddr, 1'b0)) begin
        unique case (idx)
          IDX_PUMP_MIXER: st_d.prdata[7:0] = st_q.pm;
          IDX_ADC_DITHER: st_d.prdata[7:0] = st_q.ad;
          IDX_VGA_COUPLER: st_d.prdata[3:0] = st_q.vc;
          IDX_VGA_STAGE: st_d.prdata[5:0] = st_q.vs;
          IDX_TEST_MODULE: st_d.prdata[3:0] = st_q.tm_ctrl;
          IDX_CARRIER_LEVEL: st_d.prdata[6:0] = st_q.cs_level;
          IDX_STATUS: st_d.prdata[7:0] = status;
          IDX_RESET_OK: st_d.prdata[7:0] = reset_ok_i;
          default: st_d.prdata = 32'h0000_0000;
        endcase
      end
    end
    // Calibration flag: done wins over a start in the same cycle
    if (cal_start_i) begin
      st_d.cal_complete = 1'b0;
    end
    if (cal_done_i) begin
      st_d.cal_complete = 1'b1;
    end
    // Fault sticks until the next sequence; a failure wins
    if (seq_start_i) begin
      st_d.seq_fault = 1'b0;
    end
    if (seq_lock_fail_i) begin
      st_d.seq_fault = 1'b1;
    end
    // Rotation parks at step zero while disabled
    if (st_q.ad.common_mode_rotation_off) begin
      st_d.rot_idx = 2'd0;
    end else if (rotate_step_i) begin
      st_d.rot_idx = st_q.rot_idx + 2'd1;
    end
    st_d.rot_pos = rotation_lookup(st_q.ad.rotation_mode, st_d.rot_idx);
    // Test module follows all interface bits while routed; unrouted, it follows only mode bits 1:0
    if (st_q.pm.test_module_to_filter ||
        st_q.pm.test_module_to_converter) begin
      st_d.tm_pd = st_q.tm_ctrl[3];
      st_d.tm_mode = st_q.tm_ctrl[2:0];
    end else begin
      st_d.tm_pd = 1'b1;
      st_d.tm_mode = TEST_MODE_IDLE | {1'b0, st_q.tm_ctrl[1:0]};
    end
    // Gain chain: override values replace the AGC setting
    if (st_q.vc.vga_override) begin
      st_d.vga.coupler_one_gain = st_q.vc.coupler_one_gain;
      st_d.vga.coupler_two_gain = st_q.vc.coupler_two_gain;
      st_d.vga.stages = st_q.vs;
    end else begin
      st_d.vga = agc_setting_i;
    end
    // Converter test output takes over all three pads
    if (st_q.ad.converter_test_out) begin
      st_d.pins.lock = adc_sample_i[1];
      st_d.pins.data = adc_sample_i[0];
      st_d.pins.data_clock = adc_clk_i;
      st_d.pins.data_oe = 1'b1;
    end else begin
      st_d.pins = normal_pins_i;
    end
  end

  // ********************************************************************
  // State register
  // ********************************************************************
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= '0;
      st_q.pm <= RST_PUMP_MIXER;
      st_q.ad <= RST_ADC_DITHER;
      st_q.vc <= RST_VGA_COUPLER;
      st_q.vs <= RST_VGA_STAGE;
      st_q.tm_ctrl <= RST_TEST_MODULE;
      st_q.cs_level <= RST_CARRIER_LEVEL;
      st_q.tm_pd <= 1'b1;
      st_q.tm_mode <= TEST_MODE_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign apb_o.pready = 1'b1; // Never stalls
  assign apb_o.prdata = st_q.prdata;
  assign apb_o.pslverr = st_q.pslverr;
  assign pump_normal_off_o = st_q.pm.pump_normal_off;
  assign pump_force_up_o = st_q.pm.pump_force_up;
  assign pump_force_down_o = st_q.pm.pump_force_down;
  assign mixer_dc_control_en_o = st_q.pm.mixer_dc_control_en;
  // Polarity is only meaningful while DC control is on
  assign mixer_dc_polarity_o = st_q.pm.mixer_dc_polarity;
  assign test_module_to_filter_o = st_q.pm.test_module_to_filter;
  assign test_module_to_converter_o =
    st_q.pm.test_module_to_converter;
  assign test_module_powerdown_o = st_q.tm_pd;
  assign test_mode_o = st_q.tm_mode;
  assign freq_comp_out_en_o = st_q.ad.freq_comp_out_en;
  assign sigma_clock_dither_en_o = st_q.ad.sigma_clock_dither_en;
  assign integrator_chop_off_o = st_q.ad.integrator_chop_off;
  assign feedback_shaping_off_o = st_q.ad.feedback_shaping_off;
  assign common_mode_rotation_off_o = st_q.ad.common_mode_rotation_off;
  assign rotation_position_o = st_q.rot_pos;
  assign vga_setting_o = st_q.vga;
  assign pins_o = st_q.pins;

  // ********************************************************************
  // Checks
  // ********************************************************************
  pump_write_a: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    wr_access && idx == IDX_PUMP_MIXER |=> pump_normal_off_o ==
    $past(apb_i.pwdata[7]) && pump_force_up_o == $past(apb_i.pwdata[6]))
    else $error("pump bits did not follow write");

  mixer_dc_a: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    wr_access && idx == IDX_PUMP_MIXER |=> mixer_dc_polarity_o ==
    $past(apb_i.pwdata[4:3]) && mixer_dc_control_en_o ==
    $past(apb_i.pwdata[2]))
    else $error("mixer dc control did not follow write");

  module_idle_a: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    !(test_module_to_filter_o || test_module_to_converter_o) |=>
    test_module_powerdown_o && test_mode_o[2])
    else $error("test module not idle while unrouted");

  pad_takeover_a: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    st_q.ad.converter_test_out |=> pins_o.lock == $past(adc_sample_i[1])
    && pins_o.data_clock == $past(adc_clk_i) && pins_o.data_oe)
    else $error("pads not carrying converter samples");

  rotate_fixed_a: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    st_q.ad.rotation_mode == ROT_MODE_FIXED [*2] |-> rotation_position_o ==
    2'b00)
    else $error("fixed rotation left position zero");

  cal_flag_a: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    cal_start_i && !cal_done_i ##1 !cal_done_i [*3] |->
    !st_q.cal_complete)
    else $error("calibration flag set without done");

  seq_fault_a: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    seq_lock_fail_i |=> st_q.seq_fault)
    else $error("sequence fault not raised");

  vga_override_a: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    st_q.vc.vga_override |=> vga_setting_o.stages == $past(st_q.vs) &&
    vga_setting_o.coupler_two_gain == $past(st_q.vc.coupler_two_gain))
    else $error("override values not applied");

  dither_reset_a: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    $rose(reset_n_i) |-> sigma_clock_dither_en_o)
    else $error("dither not on after reset");

endmodule : rf_test_and_status_registers

// [testbench/tb.sv]
// Self-checking bench for the radio test and status register bank
`timescale 1ns/100ps
`define CHK(n, e, s) begin compares++; if ((e) !== (s)) begin mismatches++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module tb;
  import radio_test_pkg::*;
  // ****************************************************************
  // Stimulus and observed signals, named as the ports (.* hookup)
  // ****************************************************************
  logic ref_clk_i = 0, reset_n_i = 0, rotate_step_i = 0, adc_clk_i = 0;
  logic lock_pin_i = 0, data_clock_pin_i = 0, data_pin_i = 0;
  logic cal_start_i = 0, cal_done_i = 0, seq_start_i = 0;
  logic seq_lock_fail_i = 0, pll_lock_raw_i = 0, pll_lock_filtered_i = 0;
  logic [1:0] adc_sample_i = 0, mixer_dc_polarity_o, rotation_position_o;
  logic [6:0] rssi_i = 0;
  logic [2:0] test_mode_o;
  apb_req_t apb_i = '0;
  apb_rsp_t apb_o;
  vga_setting_t agc_setting_i = '0, vga_setting_o;
  pin_drive_t normal_pins_i = '0, pins_o;
  reset_ok_t reset_ok_i = '0;
  logic pump_normal_off_o, pump_force_up_o, pump_force_down_o;
  logic mixer_dc_control_en_o, test_module_to_filter_o;
  logic test_module_to_converter_o, test_module_powerdown_o;
  logic freq_comp_out_en_o, sigma_clock_dither_en_o, integrator_chop_off_o;
  logic feedback_shaping_off_o, common_mode_rotation_off_o;
  logic [31:0] rd, v;
  logic er;
  int mismatches = 0, compares = 0;
  logic [1:0] rix = 2'd0; // Reference rotation step
  logic [8:0] e9; // Expected gain setting
  logic [3:0] e4; // Expected pad drive
  wire [7:0] pump_seen = {pump_normal_off_o, pump_force_up_o,
    pump_force_down_o, mixer_dc_polarity_o, mixer_dc_control_en_o,
    test_module_to_filter_o, test_module_to_converter_o};
  wire [4:0] conv_seen = {freq_comp_out_en_o, sigma_clock_dither_en_o,
    integrator_chop_off_o, feedback_shaping_off_o,
    common_mode_rotation_off_o};
  wire [3:0] tm_seen = {test_module_powerdown_o, test_mode_o};
  rf_test_and_status_registers i_rf_test_and_status_registers (.*);
  always #5 ref_clk_i = ~ref_clk_i;
  // Random rotation steps keep the rotation logic moving
  always @(posedge ref_clk_i) rotate_step_i <= 1'($urandom);
  // Reference step count: parked at zero while rotation is off
  always @(posedge ref_clk_i) begin
    if (!reset_n_i || common_mode_rotation_off_o) rix <= 2'd0;
    else rix <= rix + 2'(rotate_step_i);
  end
  // One APB transfer; idle cycle before each setup keeps drivers apart
  task apb(input logic w, input logic [7:0] ix, input logic [31:0] d);
    @(posedge ref_clk_i);
    apb_i <= {1'b1, 1'b0, w, 2'b00, ix, 2'b00, d};
    @(posedge ref_clk_i);
    apb_i.penable <= 1'b1;
    @(posedge ref_clk_i);
    while (apb_o.pready !== 1'b1) @(posedge ref_clk_i);
    rd = apb_o.prdata;
    er = apb_o.pslverr;
    apb_i <= '0;
  endtask : apb
  // Unrouted test module is parked: powered down, mode bit 2 high
  function automatic logic [3:0] tm_exp(logic [7:0] pm, logic [3:0] tm);
    return (pm[1] | pm[0]) ? tm : {2'b11, tm[1:0]};
  endfunction : tm_exp
  // Expected rotation position: two-bit steps per mode, step 0 lowest
  function automatic logic [1:0] rot_exp(logic [1:0] m, logic [1:0] i);
    logic [7:0] t;
    t = (m == 2'd0) ? 8'he4 : (m == 2'd1) ? 8'h78 :
        (m == 2'd2) ? 8'h00 : 8'h88;
    return t[2*i +: 2];
  endfunction : rot_exp
  task report_and_stop;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(40061));
    repeat (4) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    `CHK("dither", sigma_clock_dither_en_o, 1'b1)
    `CHK("tm", {test_module_powerdown_o, test_mode_o}, 4'hc)
    apb(0, IDX_PUMP_MIXER, 0);
    `CHK("pm rst", rd, 32'h0000_0000)
    apb(0, IDX_ADC_DITHER, 0);
    `CHK("ad rst", rd, 32'h0000_0040)
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      v = $urandom;
      agc_setting_i <= 9'($urandom);
      adc_sample_i <= 2'($urandom);
      adc_clk_i <= 1'($urandom);
      normal_pins_i <= 4'($urandom);
      apb(1, IDX_PUMP_MIXER, {24'h0, v[7:0]});
      apb(1, IDX_ADC_DITHER, {24'h0, v[15:8]});
      apb(1, IDX_VGA_COUPLER, {28'h0, v[19:16]});
      apb(1, IDX_VGA_STAGE, {26'h0, v[29:24]}); // Reserved kept 0
      apb(1, IDX_TEST_MODULE, {28'h0, v[23:20]});
      apb(0, IDX_VGA_STAGE, 0);
      `CHK("stage rd", rd, {26'h0, v[29:24]})
      e9 = v[19] ? {v[18:16], v[29:24]} : agc_setting_i;
      e4 = v[13] ? {adc_sample_i[1], adc_clk_i, adc_sample_i[0], 1'b1}
                 : normal_pins_i;
      `CHK("pump", pump_seen, v[7:0])
      `CHK("adc", conv_seen, {v[15:14], v[12:10]})
      `CHK("vga", vga_setting_o, e9)
      `CHK("tm", tm_seen, tm_exp(v[7:0], v[23:20]))
      `CHK("pins", pins_o, e4)
      `CHK("rot seq", rotation_position_o, rot_exp(v[9:8], rix))
      if (v[10] || v[9:8] == ROT_MODE_FIXED) begin
        `CHK("rot", rotation_position_o, 2'b00)
      end
      if (!v[10] && v[9:8] == ROT_MODE_PAIR) begin
        `CHK("rot", rotation_position_o[0], 1'b0)
      end
    end
    $display("test controls done");
    // Mid-run reset: written controls fall back to their defaults
    reset_n_i <= 1'b0;
    @(posedge ref_clk_i) reset_n_i <= 1'b1;
    `CHK("dither", sigma_clock_dither_en_o, 1'b1)
    `CHK("pm rst", pump_seen, RST_PUMP_MIXER)
    `CHK("tm", tm_seen, 4'hc)
    $display("test reset again done");
    v = {25'h0, 7'($urandom)};
    apb(1, IDX_CARRIER_LEVEL, v);
    rssi_i <= 7'($urandom);
    {lock_pin_i, data_clock_pin_i, data_pin_i} <= 3'($urandom);
    {pll_lock_raw_i, pll_lock_filtered_i} <= 2'($urandom);
    reset_ok_i <= 8'($urandom);
    cal_start_i <= 1'b1;
    @(posedge ref_clk_i) cal_start_i <= 1'b0;
    apb(0, IDX_CARRIER_LEVEL, 0);
    `CHK("cs lvl", rd, v)
    apb(0, IDX_STATUS, 0);
    `CHK("cal", rd[7], 1'b0)
    `CHK("lk", rd[5:4], {pll_lock_raw_i, pll_lock_filtered_i})
    `CHK("cs", rd[3], 1'(rssi_i > v[6:0]))
    `CHK("pins", rd[2:0], {lock_pin_i, data_clock_pin_i, data_pin_i})
    {cal_done_i, seq_lock_fail_i} <= 2'b11;
    rssi_i <= v[6:0]; // Equal to threshold: no carrier
    @(posedge ref_clk_i) {cal_done_i, seq_lock_fail_i} <= 2'b00;
    apb(0, IDX_STATUS, 0);
    `CHK("cal seq", rd[7:6], 2'b11)
    `CHK("cs eq", rd[3], 1'b0)
    // A start alone clears both flags
    {cal_start_i, seq_start_i} <= 2'b11;
    @(posedge ref_clk_i) {cal_start_i, seq_start_i} <= 2'b00;
    apb(0, IDX_STATUS, 0);
    `CHK("cal clr", rd[7:6], 2'b00)
    // Set and clear in one cycle: the set wins
    {cal_start_i, cal_done_i} <= 2'b11;
    {seq_start_i, seq_lock_fail_i} <= 2'b11;
    @(posedge ref_clk_i);
    {cal_start_i, cal_done_i, seq_start_i, seq_lock_fail_i} <= 4'h0;
    apb(0, IDX_STATUS, 0);
    `CHK("set wins", rd[7:6], 2'b11)
    apb(0, IDX_RESET_OK, 0);
    `CHK("rst ok", rd, {24'h0, reset_ok_i})
    apb(1, IDX_STATUS, 32'h0000_00ff);
    `CHK("ro err", er, 1'b1)
    apb(0, 8'h3f, 0);
    `CHK("unmapped", er, 1'b1)
    $display("test status done");
    report_and_stop;
  end
  // Watchdog: the sequence needs well under 2000 cycles
  initial begin
    #200000;
    mismatches++;
    report_and_stop;
  end
endmodule : tb
